// *** logic/ssp_pkg.sv ***
package ssp_pkg;
    // =========================================================
    // geometry
    localparam int ADDR_W    = 18;
    localparam int LANE_W    = 8;
    localparam int LANES     = 2;
    localparam int DATA_W    = LANE_W * LANES;
    localparam int DEPTH     = 262144;
    // =========================================================
    // sleep entry is asynchronous; exit takes two cycles
    localparam int SLEEP_CYC = 2;
    localparam logic [1:0] SLEEP_CNT_MAX = 2'h1;
    localparam logic [1:0] BURST_ONE     = 2'h1;
    localparam logic [1:0] BURST_ZERO    = 2'h0;
    // =========================================================
    // controls sampled at a qualified edge
    typedef struct packed {
        logic                 chip_select_a_n;
        logic                 chip_select_b;
        logic                 chip_select_c_n;
        logic                 write_n;
        logic                 advance_or_load;
        logic [LANES-1:0]     byte_write_sel_n;
        logic [ADDR_W-1:0]    addr;
    } ssp_ctrl_s;

    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_READ,
        SSP_WRITE
    } ssp_op_e;
endpackage : ssp_pkg

// *** logic/ssp_burst_addr.sv ***
`timescale 1ns/1ps
// =========================================================
// burst address sequencer for the two low address bits
module ssp_burst_addr (
    // start bits and count
    input  wire logic [1:0] start_bits,
    input  wire logic [1:0] count,
    // order select, high for interleaved
    input  wire logic       interleave,
    // result
    output logic      [1:0] burst_bits
);
    assign burst_bits = interleave ? (start_bits ^ count)
                                   : 2'(start_bits + count);
endmodule : ssp_burst_addr

// *** logic/ssp_port_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - selected only when select a low, select b high, select c low
// - output enable acts at once, combined with synchronous direction logic
// - output enable low lets pins drive reads; high makes them inputs only
// - float outputs in write data cycle, first cycle after deselect, and deselected
// - edges count only while clock qualify is low; otherwise operation state holds
// - raising clock qualify keeps previous operation and outputs, no deselect
// - sleep request enters low-activity sleep asynchronously; array contents kept
// - write data is captured from the pins at the rising edge
// - read data of the latched location flows through in the same cycle
// - parity lines behave as data of their byte lane
// - burst order strap: low linear, high interleaved
// - read starts with all selects active, write high, load low
// - write data is taken at the edge after the address edge
// - unselected byte lanes keep their stored contents on writes
// - sleep entry is asynchronous, exit takes two cycles; deselect before sleep
module ssp_port_ctrl (
    // clock and reset
    input  wire logic                       CLOCK,
    input  wire logic                       RST_N,
    // synchronous controls
    input  wire logic                       CLOCK_QUALIFY_N,
    input  wire ssp_pkg::ssp_ctrl_s         CTRL,
    // asynchronous controls and strap
    input  wire logic                       OUTPUT_EN_N,
    input  wire logic                       SLEEP_REQ,
    input  wire logic                       BURST_MODE,
    // data and parity lines, three signals each
    input  wire logic [ssp_pkg::DATA_W-1:0] DATA_IN,
    output logic      [ssp_pkg::DATA_W-1:0] DATA_OUT,
    output logic                            DATA_OE,
    input  wire logic [ssp_pkg::LANES-1:0]  PARITY_IN,
    output logic      [ssp_pkg::LANES-1:0]  PARITY_OUT,
    output logic                            PARITY_OE,
    // status
    output logic                            SLEEPING
);
    localparam int LW = ssp_pkg::LANE_W + 1;
    localparam int AW = ssp_pkg::ADDR_W;

    // =========================================================
    // storage, parity kept beside its lane
    logic [LW-1:0] mem_lo [ssp_pkg::DEPTH];
    logic [LW-1:0] mem_hi [ssp_pkg::DEPTH];

    ssp_pkg::ssp_op_e op_r;
    logic [AW-1:0]    base_r;
    logic [1:0]       cnt_r;
    logic [1:0]       bw_n_r;
    logic             desel_prev_r;
    logic             first_after;
    logic [1:0]       zz_cnt_r;
    logic             asleep_r;
    logic             mode_r;
    logic [LW-1:0]    rd_lo;
    logic [LW-1:0]    rd_hi;
    logic [1:0]       low_bits;
    logic [AW-1:0]    cur_addr;
    logic             qual;
    logic             sel;
    logic             drive;

    // sleep gates the clock qualification; an idle edge keeps state
    assign qual = !CLOCK_QUALIFY_N && !asleep_r;
    assign sel  = !CTRL.chip_select_a_n && CTRL.chip_select_b
               && !CTRL.chip_select_c_n;

    // =========================================================
    // burst order strap, caught clocked after reset release
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= 1'b1;
        end else begin
            mode_r <= BURST_MODE;
        end
    end

    ssp_burst_addr u_burst (
        .start_bits (base_r[1:0]),
        .count      (cnt_r),
        .interleave (mode_r),
        .burst_bits (low_bits)
    );
    assign cur_addr = {base_r[AW-1:2], low_bits};

    // =========================================================
    // operation pipeline
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            op_r   <= ssp_pkg::SSP_IDLE;
            base_r <= '0;
            cnt_r  <= ssp_pkg::BURST_ZERO;
            bw_n_r <= '1;
        end else if (qual) begin
            if (!CTRL.advance_or_load) begin
                base_r <= CTRL.addr;
                cnt_r  <= ssp_pkg::BURST_ZERO;
                bw_n_r <= CTRL.byte_write_sel_n;
                if (!sel) begin
                    op_r <= ssp_pkg::SSP_IDLE;
                end else if (CTRL.write_n) begin
                    op_r <= ssp_pkg::SSP_READ;
                end else begin
                    op_r <= ssp_pkg::SSP_WRITE;
                end
            end else begin
                // advance ignores selects and write enable
                cnt_r  <= 2'(cnt_r + ssp_pkg::BURST_ONE);
                bw_n_r <= CTRL.byte_write_sel_n;
            end
        end
    end

    // =========================================================
    // emerging from deselect blanks the first cycle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            desel_prev_r  <= 1'b1;
        end else if (qual) begin
            desel_prev_r  <= (op_r == ssp_pkg::SSP_IDLE);
        end
    end
    // combinational, so the blank covers the very cycle after the deselect
    assign first_after = desel_prev_r && (op_r != ssp_pkg::SSP_IDLE);

    // =========================================================
    // array write: data taken at the edge after the address
    always_ff @(posedge CLOCK) begin
        if (qual && op_r == ssp_pkg::SSP_WRITE) begin
            if (!bw_n_r[0]) begin
                mem_lo[cur_addr] <= {PARITY_IN[0], DATA_IN[7:0]};
            end
            if (!bw_n_r[1]) begin
                mem_hi[cur_addr] <= {PARITY_IN[1], DATA_IN[15:8]};
            end
        end
    end

    // =========================================================
    // flow-through read of the latched location
    assign rd_lo = mem_lo[cur_addr];
    assign rd_hi = mem_hi[cur_addr];

    // the array cells are the flops; an output register would cost a cycle
    assign DATA_OUT   = {rd_hi[ssp_pkg::LANE_W-1:0], rd_lo[ssp_pkg::LANE_W-1:0]};
    assign PARITY_OUT = {rd_hi[ssp_pkg::LANE_W], rd_lo[ssp_pkg::LANE_W]};

    // =========================================================
    // direction: output enable is combined without a clock
    assign drive = !OUTPUT_EN_N
                && (op_r == ssp_pkg::SSP_READ)
                && !first_after
                && !asleep_r;
    assign DATA_OE   = drive;
    assign PARITY_OE = drive;

    // =========================================================
    // sleep: asynchronous entry, two-cycle settle on exit
    always_ff @(posedge CLOCK or posedge SLEEP_REQ or negedge RST_N) begin
        if (!RST_N) begin
            asleep_r <= 1'b0;
            zz_cnt_r <= ssp_pkg::BURST_ZERO;
        end else if (SLEEP_REQ) begin
            asleep_r <= 1'b1;
            zz_cnt_r <= ssp_pkg::BURST_ZERO;
        end else if (asleep_r) begin
            if (zz_cnt_r == ssp_pkg::SLEEP_CNT_MAX) begin
                asleep_r <= 1'b0;
            end
            zz_cnt_r <= 2'(zz_cnt_r + ssp_pkg::BURST_ONE);
        end
    end
    assign SLEEPING = asleep_r;

    // =========================================================
    // checks
    a_desel_float: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op_r == ssp_pkg::SSP_IDLE) |-> !DATA_OE)
        else $error("data driven while deselected");
    a_oe_high_float: assert property (@(posedge CLOCK) disable iff (!RST_N)
        OUTPUT_EN_N |-> !DATA_OE && !PARITY_OE)
        else $error("data driven with output enable high");
    a_write_float: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op_r == ssp_pkg::SSP_WRITE) |-> !DATA_OE)
        else $error("data driven in write data cycle");
    a_hold_state: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLOCK_QUALIFY_N |=> $stable(op_r) && $stable(cnt_r))
        else $error("state moved on an unqualified edge");
    a_select_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && sel && CTRL.write_n && !CTRL.advance_or_load
        |=> op_r == ssp_pkg::SSP_READ)
        else $error("read not started");
    a_deselect_op: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && !sel && !CTRL.advance_or_load
        |=> op_r == ssp_pkg::SSP_IDLE)
        else $error("deselect not taken");
    a_emerge_blank: assert property (@(posedge CLOCK) disable iff (!RST_N)
        desel_prev_r && op_r != ssp_pkg::SSP_IDLE
        |-> !DATA_OE)
        else $error("first cycle after deselect driven");
    a_parity_match: assert property (@(posedge CLOCK) disable iff (!RST_N)
        DATA_OE == PARITY_OE)
        else $error("parity direction differs from data");
    a_burst_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && CTRL.advance_or_load && cnt_r == 2'h3
        |=> cnt_r == 2'h0)
        else $error("burst count did not wrap");
    a_sleep_exit: assert property (@(posedge CLOCK) disable iff (!RST_N || SLEEP_REQ)
        $fell(SLEEP_REQ) |-> ##[1:3] !asleep_r)
        else $error("sleep exit too slow");

    // =========================================================
    // operation steps, as named sequences
    sequence s_read_start;
        qual && sel && CTRL.write_n && !CTRL.advance_or_load;
    endsequence

    sequence s_write_start;
        qual && sel && !CTRL.write_n && !CTRL.advance_or_load;
    endsequence

    sequence s_advance;
        qual && CTRL.advance_or_load;
    endsequence

    sequence s_frozen;
        !qual;
    endsequence

    a_write_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_write_start
        |=> op_r == ssp_pkg::SSP_WRITE)
        else $error("write not started");

    a_load_base: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_read_start
        |=> base_r == $past(CTRL.addr) && cnt_r == ssp_pkg::BURST_ZERO)
        else $error("read address not latched");

    a_adv_keeps_op: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_advance
        |=> $stable(op_r))
        else $error("advance changed the operation");

    a_adv_count: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_advance
        |=> cnt_r == 2'($past(cnt_r) + ssp_pkg::BURST_ONE))
        else $error("burst count did not step");

    a_frozen_regs: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_frozen
        |=> $stable(base_r) && $stable(bw_n_r) && $stable(desel_prev_r))
        else $error("state moved while frozen");

    a_sleep_float: assert property (@(posedge CLOCK) disable iff (!RST_N)
        asleep_r
        |-> !DATA_OE && !PARITY_OE)
        else $error("data driven while asleep");

    a_sleep_enter: assert property (@(posedge CLOCK) disable iff (!RST_N)
        SLEEP_REQ
        |-> asleep_r)
        else $error("sleep not entered");

    a_wake_steps: assert property (@(posedge CLOCK) disable iff (!RST_N || SLEEP_REQ)
        $fell(SLEEP_REQ)
        |=> asleep_r)
        else $error("sleep left too early");

    a_oe_low_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !OUTPUT_EN_N && op_r == ssp_pkg::SSP_READ && !first_after && !asleep_r
        |-> DATA_OE)
        else $error("read data not driven");

    a_desel_parity: assert property (@(posedge CLOCK) disable iff (!RST_N)
        op_r == ssp_pkg::SSP_IDLE
        |-> !PARITY_OE)
        else $error("parity driven while deselected");

    a_lo_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && op_r == ssp_pkg::SSP_WRITE && !bw_n_r[0]
        |=> mem_lo[$past(cur_addr)] == $past({PARITY_IN[0], DATA_IN[7:0]}))
        else $error("low lane not written");

    a_hi_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && op_r == ssp_pkg::SSP_WRITE && !bw_n_r[1]
        |=> mem_hi[$past(cur_addr)] == $past({PARITY_IN[1], DATA_IN[15:8]}))
        else $error("high lane not written");

    a_lo_keep: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && op_r == ssp_pkg::SSP_WRITE && bw_n_r[0]
        |=> mem_lo[$past(cur_addr)] == $past(mem_lo[cur_addr]))
        else $error("low lane changed without select");

    a_hi_keep: assert property (@(posedge CLOCK) disable iff (!RST_N)
        qual && op_r == ssp_pkg::SSP_WRITE && bw_n_r[1]
        |=> mem_hi[$past(cur_addr)] == $past(mem_hi[cur_addr]))
        else $error("high lane changed without select");

    // the strap is static, so a one-cycle lag after a change is harmless
    a_mode_follow: assert property (@(posedge CLOCK) disable iff (!RST_N)
        1'b1
        |=> mode_r == $past(BURST_MODE))
        else $error("burst order not taken from strap");
endmodule : ssp_port_ctrl

// *** bench/ssp_ctrl_model.sv ***
`timescale 1ns/1ps
// =========================================================
// memory controller on the far side of the port
module ssp_ctrl_model (
    // clock
    input  wire logic          CLOCK,
    // controls towards the port
    output ssp_pkg::ssp_ctrl_s ctrl,
    output logic               qual_n,
    output logic               oe_n,
    // write data drive
    output logic [17:0]        wdata,
    output logic               wdrive
);
    logic        pend;
    logic [17:0] pd;
    initial begin
        ctrl   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 18'h0_0000};
        {qual_n, oe_n, wdrive, pend} = 4'h0;
        {wdata, pd} = 36'h0_0000_0000;
    end
    // caller sits at a falling edge; one full cycle passes
    task automatic op(input logic [2:0] sel, input logic wr_n, input logic adv,
                      input logic [1:0] bw, input logic [17:0] a, input logic [17:0] d);
        wdrive = pend;
        wdata  = pd;
        pend   = !wr_n && sel == 3'h2 && !adv;
        pd     = d;
        ctrl   = '{sel[2], sel[1], sel[0], wr_n, adv, bw, a};
        @(negedge CLOCK);
    endtask : op
    // output enable is asynchronous; the caller picks the moment
    task automatic set_oe(input logic v);
        oe_n = v;
    endtask : set_oe
    // stretch the cycle; select b drops meanwhile to prove the controls are ignored
    task automatic hold(input int n);
        ssp_pkg::ssp_ctrl_s keep;
        keep   = ctrl;
        qual_n = 1'b1;
        ctrl.chip_select_b = 1'b0;
        repeat (n) @(negedge CLOCK);
        ctrl   = keep;
        qual_n = 1'b0;
    endtask : hold
endmodule : ssp_ctrl_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic               CLOCK = 0, RST_N = 0, SLEEP_REQ = 0, BURST_MODE = 0;
    ssp_pkg::ssp_ctrl_s ctrl;
    logic               qual_n, oe_n, wdrive, data_oe, par_oe, sleeping;
    logic [17:0]        wdata, last_r = 18'h0_0000;
    logic [15:0]        pin_d, d_out;
    logic [1:0]         pin_p, p_out;
    int                 failures = 0, comparisons = 0;
    always #4 CLOCK = ~CLOCK;
    // released lines show the inverse of their last level, never a stale copy
    assign pin_d = data_oe ? d_out : (wdrive ? wdata[15:0] : ~last_r[15:0]);
    assign pin_p = par_oe ? p_out : (wdrive ? wdata[17:16] : ~last_r[17:16]);
    always @(posedge CLOCK) last_r <= {pin_p, pin_d};
    ssp_ctrl_model m_ctrl (.CLOCK(CLOCK), .ctrl(ctrl), .qual_n(qual_n), .oe_n(oe_n),
                           .wdata(wdata), .wdrive(wdrive));
    ssp_port_ctrl u_ssp_port_ctrl (.CLOCK(CLOCK), .RST_N(RST_N), .CLOCK_QUALIFY_N(qual_n),
        .CTRL(ctrl), .OUTPUT_EN_N(oe_n), .SLEEP_REQ(SLEEP_REQ), .BURST_MODE(BURST_MODE),
        .DATA_IN(pin_d), .DATA_OUT(d_out), .DATA_OE(data_oe), .PARITY_IN(pin_p),
        .PARITY_OUT(p_out), .PARITY_OE(par_oe), .SLEEPING(sleeping));
    // =========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [17:0] val(input logic [17:0] a);
        return {a[1:0], a[7:0] ^ 8'h5A, a[7:0]};
    endfunction : val
    task automatic rd(input logic [17:0] a, input logic [17:0] e);
        m_ctrl.op(3'h2, 1'b1, 1'b0, 2'h3, a, 18'h0_0000);
        check({13'h0000, data_oe, pin_p, pin_d}, {13'h0000, 1'b1, e});
    endtask : rd
    task automatic wrap_up;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // =========================================================
    // scenarios
    task automatic t_rw;
        logic [17:0] v;
        for (int a = 4; a < 12; a++) m_ctrl.op(3'h2, 1'b0, 1'b0, 2'h0, 18'(a), val(18'(a)));
        m_ctrl.op(3'h2, 1'b0, 1'b0, 2'h1, 18'h0_0004, 18'h3_FFFF);
        check({31'h0000_0000, data_oe}, 32'h0000_0000);
        v = val(18'h0_0004);
        rd(18'h0_0004, {1'b1, v[16], 8'hFF, v[7:0]});
        rd(18'h0_0005, val(18'h0_0005));
        $display("t_rw done");
    endtask : t_rw
    task automatic t_select;
        for (int i = 0; i < 8; i++) begin
            m_ctrl.op(i[2:0], 1'b1, 1'b0, 2'h3, 18'h0_0005, 18'h0_0000);
            check({31'h0000_0000, data_oe}, 32'h0000_0000);
            m_ctrl.op(i[2:0], 1'b1, 1'b0, 2'h3, 18'h0_0005, 18'h0_0000);
            check({31'h0000_0000, data_oe}, {31'h0000_0000, i == 2});
        end
        $display("t_select done");
    endtask : t_select
    task automatic t_oe_qual;
        // a read right after a deselect is blanked, so prime the port first
        m_ctrl.op(3'h2, 1'b1, 1'b0, 2'h3, 18'h0_0006, 18'h0_0000);
        rd(18'h0_0006, val(18'h0_0006));
        #1 m_ctrl.set_oe(1'b1);
        #1 check({31'h0000_0000, data_oe}, 32'h0000_0000);
        m_ctrl.set_oe(1'b0);
        #1 check({31'h0000_0000, data_oe}, 32'h0000_0001);
        @(negedge CLOCK);
        m_ctrl.hold(3);
        check({13'h0000, data_oe, pin_p, pin_d}, {13'h0001, val(18'h0_0006)});
        $display("t_oe_qual done");
    endtask : t_oe_qual
    task automatic t_sleep;
        m_ctrl.op(3'h7, 1'b1, 1'b0, 2'h3, 18'h0_0000, 18'h0_0000);
        SLEEP_REQ = 1'b1;
        for (int k = 0; k < 2 && sleeping !== 1'b1; k++) @(negedge CLOCK);
        check({31'h0000_0000, sleeping}, 32'h0000_0001);
        SLEEP_REQ = 1'b0;
        for (int k = 0; k < 2 && sleeping !== 1'b0; k++) @(negedge CLOCK);
        check({31'h0000_0000, sleeping}, 32'h0000_0000);
        m_ctrl.op(3'h7, 1'b1, 1'b0, 2'h3, 18'h0_0000, 18'h0_0000);
        m_ctrl.op(3'h2, 1'b1, 1'b0, 2'h3, 18'h0_0007, 18'h0_0000);
        rd(18'h0_0007, val(18'h0_0007));
        $display("t_sleep done");
    endtask : t_sleep
    task automatic t_burst;
        logic [1:0] b;
        for (int m = 0; m < 2; m++) begin
            BURST_MODE = m[0];
            rd(18'h0_0008, val(18'h0_0008));
            rd(18'h0_0009, val(18'h0_0009));
            // the fourth step wraps the count back to the start address
            for (int c = 1; c < 5; c++) begin
                b = m[0] ? (2'h1 ^ c[1:0]) : (2'h1 + c[1:0]);
                m_ctrl.op(3'h2, 1'b1, 1'b1, 2'h3, 18'h0_0009, 18'h0_0000);
                check({14'h0000, pin_p, pin_d}, {14'h0000, val({16'h0002, b})});
            end
        end
        $display("t_burst done");
    endtask : t_burst
    // =========================================================
    // sequence and hang guard
    initial begin
        repeat (20) @(negedge CLOCK);
        RST_N = 1'b1;
        t_rw();
        t_select();
        t_oe_qual();
        t_sleep();
        t_burst();
        wrap_up();
    end
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule : tb
